// *** logic/card_xfer_pkg.sv ***
// card_xfer_pkg: constants and types for the start-up card transfer selector
// assumes one 40 MHz system clock and an active-low asynchronous reset
package card_xfer_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int SW_W   = 8;
  localparam int NBANK  = 4;
  localparam int BANK_W = 2;
  // switch positions, bit 0 is position 1
  localparam int SW_DIR_POS   = 4;
  localparam int SW_STYLE_POS = 5;
  localparam logic [7:0] SW_BANK_MASK   = 8'h0F;
  localparam logic [7:0] SW_DL_OFF_MASK = 8'hF0;
  localparam logic [7:0] SW_UL_OFF_MASK = 8'hE0;
  localparam logic [7:0] SW_MANUAL_CODE = 8'h20;
  localparam logic [7:0] SW_RST         = 8'h00;
  localparam int CAP_DELAY = 2;
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_LEN  = 4'h8;
  localparam logic [3:0] OFF_SW   = 4'hC;
  localparam int CTRL_DIR     = 0;
  localparam int CTRL_BANK_LO = 1;
  localparam int CTRL_CONT_LO = 3;
  localparam int CTRL_GO      = 8;
  localparam int CTRL_CONFIRM = 9;
  localparam int STAT_MODE_LO = 0;
  localparam int STAT_BANK_LO = 2;
  localparam int STAT_BUSY    = 4;
  localparam int STAT_DONE    = 5;
  localparam int STAT_ERR     = 6;
  localparam int STAT_WAITOK  = 7;
  localparam int LEN_W = 16;
  localparam logic [15:0] LEN_RST = 16'h0100;
  localparam logic [1:0]  CONT_BOTH = 2'h1;
  localparam logic [1:0]  CONT_RST  = 2'h1;
  // pacing: one megabyte in twenty-five seconds, longest gap rounds down
  localparam int DL_BYTES  = 1_048_576;
  localparam int DL_TIME_S = 25;
  localparam int PACE_CYC  = (DL_TIME_S * CLK_HZ) / DL_BYTES;
  localparam int PACE_W    = 10;
  // indicator half period in milliseconds
  localparam int FLASH_HALF_MS  = 250;
  localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int FLASH_W        = 24;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_AUTO_DL, MODE_AUTO_UL, MODE_MANUAL} mode_type;
  typedef enum logic [2:0] {OP_NONE, OP_PROBE, OP_ERASE, OP_CREATE, OP_COPY} card_op_type;
  typedef enum logic [1:0] {LED_OFF, LED_ORANGE, LED_GREEN, LED_RED} led_type;
endpackage

// *** logic/switch_capture.sv ***
// switch_capture: synchronises the eight-position switch and decodes it once
// assumes the switch pins are asynchronous to clk_sys_in
`timescale 1ns/1ps
module switch_capture
(
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_b_in,
  input  wire logic [7:0]                sw_in,
  output card_xfer_pkg::mode_type        mode_out,
  output logic [1:0]                     bank_out,
  output logic [7:0]                     sw_cap_out,
  output logic                           cap_done_out
);
  import card_xfer_pkg::*;

  logic [7:0] sw_meta_r;
  logic [7:0] sw_sync_r;
  logic [1:0] cap_cnt_r;

  // index of the single bank position that is on
  function automatic logic [1:0] bank_index(input logic [3:0] b);
    bank_index = 2'h0;
    for (int i = 0; i < NBANK; i++)
      if (b[i]) bank_index = 2'(i);
  endfunction

  // full decode of one switch pattern
  function automatic mode_type decode(input logic [7:0] s);
    logic one;
    one = $onehot(s & SW_BANK_MASK);
    if (one && ((s & SW_DL_OFF_MASK) == SW_RST))
      decode = MODE_AUTO_DL;
    else if (one && s[SW_DIR_POS] && ((s & SW_UL_OFF_MASK) == SW_RST))
      decode = MODE_AUTO_UL;
    else if (s == SW_MANUAL_CODE)
      decode = MODE_MANUAL;
    else
      decode = MODE_NORMAL;
  endfunction

  // two-stage synchroniser
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      sw_meta_r <= SW_RST;
      sw_sync_r <= SW_RST;
    end
    else
    begin
      sw_meta_r <= sw_in;
      sw_sync_r <= sw_meta_r;
    end

  // capture once after release, then hold until the next reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      cap_cnt_r    <= 2'h0;
      cap_done_out <= 1'b0;
      sw_cap_out   <= SW_RST;
      mode_out     <= MODE_NORMAL;
      bank_out     <= 2'h0;
    end
    else if (!cap_done_out)
    begin
      if (cap_cnt_r == 2'(CAP_DELAY))
      begin
        cap_done_out <= 1'b1;
        sw_cap_out   <= sw_sync_r;
        mode_out     <= decode(sw_sync_r);
        bank_out     <= bank_index(sw_sync_r[3:0]);
      end
      else
        cap_cnt_r <= cap_cnt_r + 2'h1;
    end

  a_cap_frozen: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $past(cap_done_out) |-> $stable(sw_cap_out) && $stable(mode_out))
    else $error("captured switch pattern changed");
endmodule

// *** logic/indicator_flash.sv ***
// indicator_flash: drives the two-colour front indicator in flashing mode
// assumes orange is shown as red and green lit together
`timescale 1ns/1ps
module indicator_flash
#(
  parameter int HALF_CYC = card_xfer_pkg::FLASH_HALF_CYC
)
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_b_in,
  input  card_xfer_pkg::led_type      colour_in,
  output logic                        led_green_out,
  output logic                        led_red_out
);
  import card_xfer_pkg::*;

  logic [23:0] cnt_r;
  logic        phase_r;

  // free-running half-period timer
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
    end
    else if (cnt_r == FLASH_W'(HALF_CYC - 1))
    begin
      cnt_r   <= '0;
      phase_r <= ~phase_r;
    end
    else
      cnt_r <= cnt_r + 24'h1;

  // colour gated by flash phase
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      led_green_out <= 1'b0;
      led_red_out   <= 1'b0;
    end
    else
    begin
      led_green_out <= phase_r && (colour_in == LED_ORANGE || colour_in == LED_GREEN);
      led_red_out   <= phase_r && (colour_in == LED_ORANGE || colour_in == LED_RED);
    end
endmodule

// *** logic/card_transfer_mode_select.sv ***
// card_transfer_mode_select: start-up transfer selector and card sequencer
// assumes card handshake pins are asynchronous, memory port is on clk_sys_in
`timescale 1ns/1ps
module card_transfer_mode_select
#(
  parameter int FLASH_HALF_CYC = card_xfer_pkg::FLASH_HALF_CYC
)
(
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_b_in,
  input  wire logic [7:0]               sw_in,
  input  wire logic [3:0]               addr_in,
  input  wire logic [31:0]              wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic [31:0]                   rdata_out,
  input  wire logic                     card_present_in,
  input  wire logic                     card_ack_in,
  input  wire logic                     card_fail_in,
  input  wire logic                     card_found_in,
  input  wire logic [7:0]               card_rdata_in,
  output logic                          card_req_out,
  output card_xfer_pkg::card_op_type    card_op_out,
  output logic                          card_upload_out,
  output logic [1:0]                    card_bank_out,
  output logic [1:0]                    card_cont_out,
  output logic [7:0]                    card_wdata_out,
  output logic [15:0]                   mem_addr_out,
  output logic [7:0]                    mem_wdata_out,
  output logic                          mem_we_out,
  input  wire logic [7:0]               mem_rdata_in,
  output logic                          led_green_out,
  output logic                          led_red_out
);
  import card_xfer_pkg::*;

  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_WAITOK, ST_OP, ST_REL, ST_PACE,
                            ST_DONE, ST_FAIL} state_type;

  state_type   state_r;
  mode_type    mode;
  logic [1:0]  sw_bank;
  logic [7:0]  sw_cap;
  logic        cap_done;
  logic [3:0]  cin_meta_r;
  logic [3:0]  cin_sync_r;
  logic [7:0]  cdat_meta_r;
  logic [7:0]  cdat_sync_r;
  logic        present_s;
  logic        ack_s;
  logic        fail_s;
  logic        found_s;
  logic        found_r;
  logic        man_dir_r;
  logic [1:0]  man_bank_r;
  logic [1:0]  man_cont_r;
  logic [15:0] len_r;
  logic [15:0] cnt_r;
  logic [9:0]  pace_r;
  logic        err_r;
  logic        go_w;
  logic        confirm_w;
  logic        auto_w;
  led_type     colour_r;

  assign present_s = cin_sync_r[0];
  assign ack_s     = cin_sync_r[1];
  assign fail_s    = cin_sync_r[2];
  assign found_s   = cin_sync_r[3];
  assign auto_w    = (mode == MODE_AUTO_DL) || (mode == MODE_AUTO_UL);
  assign go_w      = wr_in && (addr_in == OFF_CTRL) && wdata_in[CTRL_GO];
  assign confirm_w = wr_in && (addr_in == OFF_CTRL) && wdata_in[CTRL_CONFIRM];

  // switch sampling and decode at start-up
  switch_capture u_switch
  (
    .clk_sys_in   (clk_sys_in),
    .rst_b_in     (rst_b_in),
    .sw_in        (sw_in),
    .mode_out     (mode),
    .bank_out     (sw_bank),
    .sw_cap_out   (sw_cap),
    .cap_done_out (cap_done)
  );

  // front indicator
  indicator_flash #(.HALF_CYC(FLASH_HALF_CYC)) u_led
  (
    .clk_sys_in    (clk_sys_in),
    .rst_b_in      (rst_b_in),
    .colour_in     (colour_r),
    .led_green_out (led_green_out),
    .led_red_out   (led_red_out)
  );

  // card pins cross into clk_sys_in through two flops
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      cin_meta_r  <= 4'h0;
      cin_sync_r  <= 4'h0;
      cdat_meta_r <= 8'h00;
      cdat_sync_r <= 8'h00;
    end
    else
    begin
      cin_meta_r  <= {card_found_in, card_fail_in, card_ack_in, card_present_in};
      cin_sync_r  <= cin_meta_r;
      cdat_meta_r <= card_rdata_in;
      cdat_sync_r <= cdat_meta_r;
    end

  // software settings for manual transfer and length
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      man_dir_r  <= 1'b0;
      man_bank_r <= 2'h0;
      man_cont_r <= CONT_RST;
      len_r      <= LEN_RST;
    end
    else if (wr_in)
    begin
      if (addr_in == OFF_CTRL)
      begin
        man_dir_r  <= wdata_in[CTRL_DIR];
        man_bank_r <= wdata_in[CTRL_BANK_LO +: BANK_W];
        man_cont_r <= wdata_in[CTRL_CONT_LO +: 2];
      end
      if (addr_in == OFF_LEN)
        len_r <= wdata_in[LEN_W-1:0];
    end

  // register read port, data valid one cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
      rdata_out <= '0;
    else
    begin
      rdata_out <= '0;
      if (rd_in)
        case (addr_in)
          OFF_CTRL:
            rdata_out <= {27'h0, man_cont_r, man_bank_r, man_dir_r};
          OFF_STAT:
          begin
            rdata_out[STAT_MODE_LO +: 2]      <= mode;
            rdata_out[STAT_BANK_LO +: BANK_W] <= card_bank_out;
            rdata_out[STAT_BUSY]   <= (state_r == ST_OP) || (state_r == ST_REL)
                                      || (state_r == ST_PACE);
            rdata_out[STAT_DONE]   <= (state_r == ST_DONE);
            rdata_out[STAT_ERR]    <= err_r;
            rdata_out[STAT_WAITOK] <= (state_r == ST_WAITOK);
          end
          OFF_LEN:
            rdata_out <= {16'h0, len_r};
          OFF_SW:
            rdata_out <= {24'h0, sw_cap};
          default:
            rdata_out <= '0;
        endcase
    end

  // transfer sequencer: probe, erase or create on upload, then paced copy
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      state_r         <= ST_BOOT;
      card_req_out    <= 1'b0;
      card_op_out     <= OP_NONE;
      card_upload_out <= 1'b0;
      card_bank_out   <= 2'h0;
      card_cont_out   <= CONT_RST;
      card_wdata_out  <= 8'h00;
      mem_addr_out    <= 16'h0;
      mem_wdata_out   <= 8'h00;
      mem_we_out      <= 1'b0;
      cnt_r           <= 16'h0;
      pace_r          <= 10'h0;
      found_r         <= 1'b0;
      err_r           <= 1'b0;
    end
    else
    begin
      mem_we_out <= 1'b0;
      case (state_r)
        ST_BOOT:
          if (cap_done)
          begin
            if (auto_w)
            begin
              card_upload_out <= (mode == MODE_AUTO_UL);
              card_bank_out   <= sw_bank;
              card_cont_out   <= CONT_BOTH;
              card_op_out     <= OP_PROBE;
              card_req_out    <= 1'b1;
              state_r         <= ST_OP;
            end
            else
              state_r <= ST_IDLE;
          end
        ST_IDLE, ST_DONE, ST_FAIL:
          if (go_w && mode == MODE_MANUAL)
          begin
            card_upload_out <= wdata_in[CTRL_DIR];
            card_bank_out   <= wdata_in[CTRL_BANK_LO +: BANK_W];
            card_cont_out   <= wdata_in[CTRL_CONT_LO +: 2];
            err_r           <= 1'b0;
            state_r         <= ST_WAITOK;
          end
        ST_WAITOK:
          if (confirm_w)
          begin
            card_op_out  <= OP_PROBE;
            card_req_out <= 1'b1;
            state_r      <= ST_OP;
          end
        ST_OP:
          if (!present_s || (ack_s && fail_s))
          begin
            card_req_out <= 1'b0;
            state_r      <= ST_FAIL;
            err_r        <= !auto_w;
          end
          else if (ack_s)
          begin
            card_req_out <= 1'b0;
            found_r      <= found_s;
            if (card_op_out == OP_COPY && !card_upload_out)
            begin
              mem_wdata_out <= cdat_sync_r;
              mem_we_out    <= 1'b1;
            end
            state_r <= ST_REL;
          end
        ST_REL:
          if (!ack_s)
          begin
            state_r <= ST_PACE;
            pace_r  <= 10'(PACE_CYC - 1);
            case (card_op_out)
              OP_PROBE:
                if (!card_upload_out && !found_r)
                begin
                  state_r <= ST_FAIL;
                  err_r   <= !auto_w;
                end
                else if (card_upload_out)
                begin
                  card_op_out  <= found_r ? OP_ERASE : OP_CREATE;
                  card_req_out <= 1'b1;
                  state_r      <= ST_OP;
                end
                else
                  cnt_r <= 16'h0;
              OP_ERASE, OP_CREATE:
                cnt_r <= 16'h0;
              default:
              begin
                cnt_r        <= cnt_r + 16'h1;
                mem_addr_out <= mem_addr_out + 16'h1;
                if (cnt_r + 16'h1 == len_r)
                  state_r <= ST_DONE;
              end
            endcase
            if (card_op_out != OP_COPY && card_op_out != OP_PROBE)
              mem_addr_out <= 16'h0;
            else if (card_op_out == OP_PROBE)
              mem_addr_out <= 16'h0;
          end
        ST_PACE:
          if (!present_s)
          begin
            state_r <= ST_FAIL;
            err_r   <= !auto_w;
          end
          else if (pace_r == 10'h0)
          begin
            card_op_out    <= OP_COPY;
            card_wdata_out <= mem_rdata_in;
            card_req_out   <= 1'b1;
            state_r        <= ST_OP;
          end
          else
            pace_r <= pace_r - 10'h1;
        default:
          state_r <= ST_BOOT;
      endcase
    end

  // indicator colour follows the automatic transfer, green after any completed transfer
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
      colour_r <= LED_OFF;
    else if (state_r == ST_DONE)
      colour_r <= LED_GREEN;
    else if (state_r == ST_FAIL && auto_w)
      colour_r <= LED_RED;
    else if (auto_w && state_r != ST_BOOT && state_r != ST_FAIL)
      colour_r <= LED_ORANGE;
    else
      colour_r <= LED_OFF;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  // length of the current pacing gap, read only by the gap check below
  logic [PACE_W-1:0] pace_len_r;
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
      pace_len_r <= '0;
    else if (state_r == ST_PACE)
      pace_len_r <= pace_len_r + PACE_W'(1);
    else
      pace_len_r <= '0;

  sequence s_probe_found_ul;
    state_r == ST_REL && !ack_s && card_op_out == OP_PROBE && card_upload_out && found_r;
  endsequence

  a_dl_decode: assert property (mode == MODE_AUTO_DL |->
    (sw_cap & SW_DL_OFF_MASK) == SW_RST && $onehot(sw_cap & SW_BANK_MASK))
    else $error("download mode from a bad pattern");
  a_ul_decode: assert property (mode == MODE_AUTO_UL |->
    sw_cap[SW_DIR_POS] && !sw_cap[SW_STYLE_POS] && $onehot(sw_cap & SW_BANK_MASK))
    else $error("upload mode from a bad pattern");
  a_manual_code: assert property (mode == MODE_MANUAL |-> sw_cap == SW_MANUAL_CODE)
    else $error("manual mode from a bad pattern");
  a_normal_idle: assert property (cap_done && !auto_w && mode != MODE_MANUAL
    && state_r != ST_BOOT |-> state_r == ST_IDLE && !card_req_out)
    else $error("transfer without a valid code");
  a_erase_first: assert property (s_probe_found_ul |=>
    state_r == ST_OP && card_op_out == OP_ERASE)
    else $error("upload did not erase an existing bank");
  a_copy_pace: assert property ($past(state_r) == ST_PACE && state_r == ST_OP
    |-> pace_len_r == PACE_W'(PACE_CYC))
    else $error("copy gap not paced");
  a_busy_orange: assert property (auto_w && state_r == ST_OP ##1 state_r == ST_OP
    |=> colour_r == LED_ORANGE)
    else $error("indicator not orange while busy");
  a_auto_no_msg: assert property (auto_w |-> !err_r)
    else $error("error flag set in automatic mode");
  a_dl_only_write: assert property (mem_we_out |-> !card_upload_out
    && $past(card_op_out) == OP_COPY)
    else $error("memory written outside a download copy");
  a_req_held: assert property (card_req_out && !ack_s && present_s && state_r == ST_OP
    |=> card_req_out)
    else $error("request dropped before acknowledge");
endmodule

// *** tb/card_model.sv ***
// card_model: behavioural removable card answering the four-phase card handshake
// assumes the selector changes its request only right after a clk_sys_in edge
`timescale 1ns/1ps
module card_model
(
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        req_in,
  input  card_xfer_pkg::card_op_type       op_in,
  input  wire logic [1:0]                  bank_in,
  input  wire logic [3:0]                  banks_in,
  input  wire logic [3:0]                  slow_in,
  output logic                             ack_out,
  output logic                             found_out,
  output logic [7:0]                       rdata_out
);
  import card_xfer_pkg::*;
  logic [7:0] cnt_r;
  logic [3:0] wait_r;
  // acknowledge after slow_in cycles, drop once the request is withdrawn
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack_out <= 1'b0;
      wait_r  <= 4'h0;
      cnt_r   <= 8'h00;
    end
    else
    begin
      wait_r <= (req_in && !ack_out) ? wait_r + 4'h1 : 4'h0;
      if (req_in && !ack_out && wait_r == slow_in)
        ack_out <= 1'b1;
      if (!req_in && ack_out)
        ack_out <= 1'b0;
      if (!req_in && ack_out && op_in == OP_COPY)
        cnt_r <= cnt_r + 8'h01;
    end
  end
  // one presence bit per bank, four banks at most
  assign found_out = ack_out ? banks_in[bank_in] : 1'b0;
  // byte only valid under ack; inverted otherwise so stale data never matches
  assign rdata_out = ack_out ? 8'hC0 + cnt_r : ~(8'hC0 + cnt_r);
endmodule

// *** tb/card_transfer_mode_select_bench.sv ***
// card_transfer_mode_select_bench: boots the selector with switch patterns
// assumes card_model on the card side and a memory echoing inverted address
`timescale 1ns/1ps
module card_transfer_mode_select_bench;
  import card_xfer_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic [7:0]  sw_in      = 8'h00;
  logic [3:0]  addr_in    = 4'h0;
  logic [31:0] wdata_in   = 32'h0;
  logic        wr_in = 1'b0, rd_in = 1'b0, req_d = 1'b0, present_r = 1'b1;
  logic [3:0]  banks_r = 4'h0, slow_r = 4'h0;
  logic [31:0] rdata_out, st;
  logic        card_ack_in, card_found_in, card_req_out, card_upload_out, mem_we_out;
  logic        led_green_out, led_red_out;
  logic [7:0]  card_rdata_in, card_wdata_out, mem_wdata_out, mem_rdata_in;
  logic [1:0]  card_bank_out, card_cont_out;
  logic [15:0] mem_addr_out;
  card_op_type card_op_out;
  card_op_type ops[$];
  logic [7:0]  mem_q[$], wd_q[$];
  int          errors = 0, checks = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  assign mem_rdata_in = ~mem_addr_out[7:0];
  card_transfer_mode_select #(.FLASH_HALF_CYC(4)) dut
  (
    .clk_sys_in, .rst_b_in, .sw_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .card_present_in(present_r), .card_ack_in, .card_fail_in(1'b0), .card_found_in,
    .card_rdata_in, .card_req_out, .card_op_out, .card_upload_out, .card_bank_out,
    .card_cont_out, .card_wdata_out, .mem_addr_out, .mem_wdata_out, .mem_we_out,
    .mem_rdata_in, .led_green_out, .led_red_out
  );
  card_model card
  (
    .clk_sys_in, .rst_b_in, .req_in(card_req_out), .op_in(card_op_out),
    .bank_in(card_bank_out), .banks_in(banks_r), .slow_in(slow_r),
    .ack_out(card_ack_in), .found_out(card_found_in), .rdata_out(card_rdata_in)
  );
  // log each new card request, each upload byte and each memory write
  always @(posedge clk_sys_in)
  begin
    req_d <= card_req_out;
    if (card_req_out && !req_d)
      ops.push_back(card_op_out);
    if (card_req_out && !req_d && card_op_out == OP_COPY)
      wd_q.push_back(card_wdata_out);
    if (mem_we_out)
      mem_q.push_back(mem_wdata_out);
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // reset with the switch set, then shorten the copy length to two bytes
  task automatic boot(input logic [7:0] sw, input logic [3:0] banks, input logic [3:0] slow);
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    sw_in    <= sw;
    banks_r  <= banks;
    slow_r   <= slow;
    present_r <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    ops.delete();
    mem_q.delete();
    wd_q.delete();
    reg_wr(OFF_LEN, 32'h2);
  endtask
  task automatic wait_end();
    int i;
    repeat (8) @(posedge clk_sys_in);
    for (i = 0; i < 2000; i++)
    begin
      reg_rd(OFF_STAT, st);
      if (st[STAT_BUSY] === 1'b0)
        break;
    end
    check("busy_end", 32'h1, 32'(i < 2000));
  endtask
  // exp bit1: green flashes, bit0: red flashes
  task automatic led_check(input logic [1:0] exp);
    int ng = 0, nr = 0;
    repeat (16)
    begin
      @(posedge clk_sys_in);
      #1 ng += (led_green_out === 1'b1);
      nr += (led_red_out === 1'b1);
    end
    check("led_green", 32'(exp[1]), 32'(ng > 0 && ng < 16));
    check("led_red", 32'(exp[0]), 32'(nr > 0 && nr < 16));
  endtask
  function automatic logic [11:0] op_seq();
    logic [11:0] s = 12'h000;
    foreach (ops[i])
      if (i < 4)
        s[3*i +: 3] = ops[i];
    return s;
  endfunction
  task automatic t_idle(input logic [7:0] sw, input mode_type m);
    boot(sw, 4'hF, 4'h0);
    repeat (40) @(posedge clk_sys_in);
    reg_rd(OFF_STAT, st);
    check("mode", 32'(m), 32'(st[STAT_MODE_LO +: 2]));
    check("req_count", 32'h0, 32'(ops.size()));
    reg_rd(OFF_SW, st);
    check("sw_reg", 32'(sw), st);
    reg_rd(OFF_LEN, st);
    check("len_reg", 32'h2, st);
    reg_rd(4'h2, st);
    check("unmapped", 32'h0, st);
  endtask
  task automatic t_download(input logic [1:0] n);
    boot(8'h01 << n, 4'hF, {2'b00, n});
    led_check(2'b11);
    reg_rd(OFF_STAT, st);
    check("dl_mode", 32'(MODE_AUTO_DL), 32'(st[STAT_MODE_LO +: 2]));
    check("dl_bank", 32'(n), 32'(st[STAT_BANK_LO +: 2]));
    check("dl_cont", 32'(CONT_BOTH), 32'(card_cont_out));
    sw_in <= 8'h20;
    wait_end();
    check("dl_done", 32'h1, 32'(st[STAT_DONE]));
    check("dl_dir", 32'h0, 32'(card_upload_out));
    check("dl_ops", {3'h0, OP_COPY, OP_COPY, OP_PROBE}, 32'(op_seq()));
    check("dl_count", 32'h2, 32'(mem_q.size()));
    check("dl_byte0", 32'hC0, 32'(mem_q[0]));
    check("dl_byte1", 32'hC1, 32'(mem_q[1]));
    led_check(2'b10);
    reg_rd(OFF_STAT, st);
    check("dl_hold", 32'(MODE_AUTO_DL), 32'(st[STAT_MODE_LO +: 2]));
    reg_rd(OFF_SW, st);
    check("sw_held", 32'(8'h01 << n), st);
  endtask
  task automatic t_upload(input logic [7:0] sw, input logic [3:0] banks,
                          input logic [11:0] exp_ops);
    boot(sw, banks, 4'h3);
    reg_rd(OFF_STAT, st);
    check("ul_mode", 32'(MODE_AUTO_UL), 32'(st[STAT_MODE_LO +: 2]));
    wait_end();
    check("ul_ops", 32'(exp_ops), 32'(op_seq()));
    check("ul_mem", 32'h0, 32'(mem_q.size()));
    check("ul_dir", 32'h1, 32'(card_upload_out));
    check("ul_wdata0", 32'hFF, 32'(wd_q[0]));
    check("ul_wdata1", 32'hFE, 32'(wd_q[1]));
    led_check(2'b10);
  endtask
  task automatic t_fail(input logic [7:0] sw, input logic [3:0] banks, input int pull);
    boot(sw, banks, 4'h2);
    if (pull > 0)
    begin
      repeat (pull) @(posedge clk_sys_in);
      present_r <= 1'b0;
    end
    wait_end();
    check("fail_ops", 32'(OP_PROBE), 32'(op_seq()));
    check("fail_mem", 32'h0, 32'(mem_q.size()));
    check("fail_err", 32'h0, 32'(st[STAT_ERR]));
    led_check(2'b01);
  endtask
  // manual download of a missing bank: go, confirm, then a flagged error
  task automatic t_manual();
    boot(8'h20, 4'h1, 4'h0);
    repeat (4) @(posedge clk_sys_in);
    reg_wr(OFF_CTRL, 32'h0000_010C);
    reg_rd(OFF_STAT, st);
    check("man_wait", 32'h1, 32'(st[STAT_WAITOK]));
    check("man_bank", 32'h2, 32'(st[STAT_BANK_LO +: 2]));
    reg_wr(OFF_CTRL, 32'h0000_0200);
    wait_end();
    check("man_ops", 32'(OP_PROBE), 32'(op_seq()));
    check("man_err", 32'h1, 32'(st[STAT_ERR]));
    led_check(2'b00);
  endtask
  task automatic give_verdict();
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // stop a hung run well beyond the expected thirteen thousand cycles
  initial
  begin
    repeat (60000) @(posedge clk_sys_in);
    errors++;
    give_verdict();
  end
  initial
  begin
    t_idle(8'h00, MODE_NORMAL);
    t_idle(8'h03, MODE_NORMAL);
    t_idle(8'h81, MODE_NORMAL);
    t_idle(8'h10, MODE_NORMAL);
    t_idle(8'h21, MODE_NORMAL);
    t_idle(8'h20, MODE_MANUAL);
    for (int n = 0; n < 4; n++)
      t_download(2'(n));
    t_upload(8'h12, 4'h2, {OP_COPY, OP_COPY, OP_ERASE, OP_PROBE});
    t_upload(8'h14, 4'h2, {OP_COPY, OP_COPY, OP_CREATE, OP_PROBE});
    t_fail(8'h04, 4'hB, 0);
    t_fail(8'h01, 4'hF, 200);
    t_manual();
    give_verdict();
  end
endmodule
